/* cdim_chan.sv */
// one input channel: selects the programmed value and its logic reading
module cdim_chan
    import cdim_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // terminal and configuration
    input wire logic i_term,
    input wire logic signed [VAL_W-1:0] i_high,
    input wire logic signed [VAL_W-1:0] i_low,
    // results
    output logic o_state,
    output logic signed [VAL_W-1:0] o_value,
    output logic o_logic
);
    logic state_d, state_q, logic_d, logic_q;
    logic signed [VAL_W-1:0] value_d, value_q;

    // resample every cycle, no filter
    always_comb begin
        state_d = i_term;
        value_d = state_q ? i_high : i_low;
        logic_d = (value_d > LOW_RST);           // zero is 0, positive is 1
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= 1'b0;
            value_q <= LOW_RST;
            logic_q <= 1'b0;
        end else begin
            state_q <= state_d;
            value_q <= value_d;
            logic_q <= logic_d;
        end
    end

    assign o_state = state_q;
    assign o_value = value_q;
    assign o_logic = logic_q;

    value_follows_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 !$past(i_rst) |-> value_q == ($past(state_q) ? $past(i_high) : $past(i_low)))
        else $error("channel value not the selected level");
    logic_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        value_q == LOW_RST |-> !logic_q)
        else $error("zero value read as logic one");
endmodule : cdim_chan

/* cdim_field.sv */
// field wiring model: switches and contactor aux contact on the terminals
module cdim_field (
    // commanded switch states and contactor coil
    input wire logic [2:0] i_switch,
    input wire logic i_coil_on,
    // terminal levels, high = 24V
    output logic [3:0] o_term
);
    timeunit 1ns;
    timeprecision 1ps;
    // normally-open aux contact follows the coil; opening it drops the fourth terminal to 0V
    assign o_term = {i_coil_on, i_switch};
endmodule : cdim_field

/* cdim_pkg.sv */
// package: register map, encodings and reset values of the digital input map
package cdim_pkg;
    // register port widths
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned VAL_W = 16;   // signed hundredths of a percent
    localparam int unsigned DEST_W = 12;  // destination parameter index
    localparam int unsigned NUM_GEN = 3;
    localparam int unsigned NUM_ALL = 4;
    // value limits in hundredths of a percent
    localparam logic signed [VAL_W-1:0] VAL_MAX = 16'sh7530;  // 300.00
    localparam logic signed [VAL_W-1:0] VAL_MIN = -16'sh7530; // -300.00
    // reset values
    localparam logic signed [VAL_W-1:0] HIGH_RST = 16'sh0001; // 0.01
    localparam logic signed [VAL_W-1:0] LOW_RST = 16'sh0000;  // 0.00
    localparam logic [DEST_W-1:0] DEST_RST_0 = 12'h05A;       // 90
    localparam logic [DEST_W-1:0] DEST_RST_1 = 12'h076;       // 118
    localparam logic [DEST_W-1:0] DEST_RST_2 = 12'h077;       // 119
    localparam logic [DEST_W-1:0] DEST_RST_3 = 12'h000;       // unrouted
    // register offsets; channel n sits at base + n*stride
    localparam logic [ADDR_W-1:0] REG_EDIT = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CH_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] REG_CH_STRIDE = 8'h10;
    localparam logic [ADDR_W-1:0] REG_HIGH = 8'h00;
    localparam logic [ADDR_W-1:0] REG_LOW = 8'h04;
    localparam logic [ADDR_W-1:0] REG_DEST = 8'h08;
    localparam logic [ADDR_W-1:0] REG_OUT = 8'h0C;
    // bit positions in the status word
    localparam int unsigned STATE_LSB = 0;
    localparam int unsigned CUT_BIT = 4;
endpackage : cdim_pkg

/* cdim_tb.sv */
// self-checking bench of the digital input map
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import cdim_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_interlock_used = 1'b0, coil = 1'b0;
    logic [2:0] sw = 3'h0;
    logic [3:0] term;
    logic [ADDR_W-1:0] i_addr = 8'h00;
    logic [DATA_W-1:0] i_wdata = 32'h0, o_rdata;
    logic [NUM_ALL*DEST_W-1:0] o_dest_index;
    logic [NUM_ALL*VAL_W-1:0] o_dest_value;
    logic [NUM_ALL-1:0] o_dest_logic, o_dest_write;
    logic o_current_off;
    logic [15:0] hi [4] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001};
    logic [15:0] lo [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [11:0] dst [4] = '{12'h05A, 12'h076, 12'h077, 12'h000};
    // row: expected current off, interlock used, coil, switches
    logic [5:0] rows [6] = '{6'h00, 6'h01, 6'h06, 6'h0F, 6'h37, 6'h1A};
    int miscompares = 0, compares = 0, cycles = 0;
    cdim_field field (.i_switch(sw), .i_coil_on(coil), .o_term(term));
    cdim_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_term(term), .i_interlock_used(i_interlock_used),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .o_dest_index(o_dest_index), .o_dest_value(o_dest_value), .o_dest_logic(o_dest_logic),
        .o_dest_write(o_dest_write), .o_current_off(o_current_off));
    // clock at 125 MHz
    initial begin
        forever #4 i_clk = ~i_clk;
    end
    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    // hang guard, well above the 140 or so cycles the tests need
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, exp);
    endtask : rd
    // edit enable around the changes, cleared afterwards to apply them
    task automatic cfg(input int n, input logic [15:0] h, input logic [15:0] l, input logic [11:0] d);
        wr(8'h00, 32'h1);
        wr(8'(8'h10 + n * 16), {16'h0, h});
        wr(8'(8'h14 + n * 16), {16'h0, l});
        wr(8'(8'h18 + n * 16), {20'h0, d});
        wr(8'h00, 32'h0);
        repeat (4) @(posedge i_clk);
    endtask : cfg
    task automatic check_all();
        logic [15:0] v;
        #1;
        for (int n = 0; n < 4; n++) begin
            v = term[n] ? hi[n] : lo[n];
            chk(o_dest_value[n*16+:16], v);
            chk(o_dest_logic[n], $signed(v) > 0);
            chk(o_dest_index[n*12+:12], dst[n]);
        end
        chk(o_dest_write, 4'hF);
        chk(o_current_off, i_interlock_used & ~term[3]);
    endtask : check_all
    task automatic settle(input logic [4:0] r);
        @(posedge i_clk);
        sw <= r[2:0];
        coil <= r[3];
        i_interlock_used <= r[4];
        repeat (3) @(posedge i_clk);
        check_all();
    endtask : settle
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_clk);
        check_all();
        rd(8'h10, 32'h1);
        rd(8'h14, 32'h0);
        rd(8'h28, 32'h76);
        rd(8'hFC, 32'h0);
        rd(8'h00, 32'h0);
        // default mapping passes every terminal through uninverted
        foreach (rows[i]) begin
            settle(rows[i][4:0]);
            chk(o_current_off, rows[i][5]);
        end
        rd(8'h04, 32'h0A);
        // numeric destination receives two fixed values
        cfg(0, 16'h03E8, 16'h0BB8, 12'h00E);
        hi[0] = 16'h03E8;
        lo[0] = 16'h0BB8;
        dst[0] = 12'h00E;
        settle(5'h01);
        settle(5'h00);
        rd(8'h1C, 32'h0BB8);
        // write with edit off is ignored, the following commit keeps old values
        wr(8'h10, 32'h0005);
        wr(8'h00, 32'h1);
        wr(8'h00, 32'h0);
        rd(8'h10, 32'h03E8);
        // swapped values invert the logic reading
        cfg(1, 16'h0000, 16'h0001, 12'h076);
        hi[1] = 16'h0000;
        lo[1] = 16'h0001;
        settle(5'h02);
        settle(5'h00);
        // out of range clamps, negative reads as logic 0
        cfg(2, 16'h7FFF, 16'hFFFB, 12'h077);
        hi[2] = 16'h7530;
        lo[2] = 16'hFFFB;
        settle(5'h04);
        settle(5'h10);
        rd(8'h04, 32'h10);
        // reset in mid-run restores the default map on every channel
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int n = 0; n < 3; n++) begin
            hi[n] = 16'h0001;
            lo[n] = 16'h0000;
        end
        dst[0] = 12'h05A;
        repeat (2) @(posedge i_clk);
        check_all();
        rd(8'h10, 32'h1);
        rd(8'h1C, 32'h0);
        conclude();
    end
endmodule : testbench

/* cdim_top.sv */
// digital input map: four terminals routed to destination parameters
//
// Our own choices: the plain strobed port and the placing of the registers.
module cdim_top
    import cdim_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // terminals: three general inputs, then the contactor interlock input
    input wire logic [NUM_ALL-1:0] i_term,
    // interlock in use (output contactor fitted)
    input wire logic i_interlock_used,
    // register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [DATA_W-1:0] o_rdata,
    // destination write stream, one channel per slot
    output logic [NUM_ALL*DEST_W-1:0] o_dest_index,
    output logic [NUM_ALL*VAL_W-1:0] o_dest_value,
    output logic [NUM_ALL-1:0] o_dest_logic,
    output logic [NUM_ALL-1:0] o_dest_write,
    // current loop disable
    output logic o_current_off
);
    // staged configuration (written while editing) and live configuration
    logic signed [VAL_W-1:0] high_st_d [NUM_ALL], high_st_q [NUM_ALL];
    logic signed [VAL_W-1:0] low_st_d [NUM_ALL], low_st_q [NUM_ALL];
    logic [DEST_W-1:0] dest_st_d [NUM_ALL], dest_st_q [NUM_ALL];
    logic signed [VAL_W-1:0] high_q [NUM_ALL], high_d [NUM_ALL];
    logic signed [VAL_W-1:0] low_q [NUM_ALL], low_d [NUM_ALL];
    logic [DEST_W-1:0] dest_q [NUM_ALL], dest_d [NUM_ALL];
    logic edit_d, edit_q;
    logic [DATA_W-1:0] rdata_d, rdata_q;
    logic [NUM_ALL-1:0] state_w, logic_w;
    logic signed [VAL_W-1:0] value_w [NUM_ALL];
    logic [NUM_ALL*DEST_W-1:0] idx_d, idx_q;
    logic [NUM_ALL*VAL_W-1:0] val_d, val_q;
    logic [NUM_ALL-1:0] lg_q, wr_q;
    logic cut_d, cut_q;

    // clamp a written value into the legal percent range
    function automatic logic signed [VAL_W-1:0] clamp(input logic [DATA_W-1:0] w);
        logic signed [VAL_W-1:0] v;
        v = w[VAL_W-1:0];
        if (v > VAL_MAX) begin
            v = VAL_MAX;
        end else if (v < VAL_MIN) begin
            v = VAL_MIN;
        end
        return v;
    endfunction : clamp

    // address of one field of channel n
    function automatic logic [ADDR_W-1:0] ch_addr(input int n, input logic [ADDR_W-1:0] f);
        return ADDR_W'(REG_CH_BASE + ADDR_W'(n) * REG_CH_STRIDE + f);
    endfunction : ch_addr

    function automatic logic [DEST_W-1:0] dest_rst(input int n);
        case (n)
            0: return DEST_RST_0;
            1: return DEST_RST_1;
            2: return DEST_RST_2;
            default: return DEST_RST_3;
        endcase
    endfunction : dest_rst

    // edit enable: staged edits only reach the live map on its clearing
    always_comb begin
        edit_d = edit_q;
        if (i_wr && i_addr == REG_EDIT) begin
            edit_d = i_wdata[0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_ALL; g++) begin : g_ch
            // staged writes are ignored while edit is off
            always_comb begin
                high_st_d[g] = high_st_q[g];
                low_st_d[g] = low_st_q[g];
                dest_st_d[g] = dest_st_q[g];
                high_d[g] = high_q[g];
                low_d[g] = low_q[g];
                dest_d[g] = dest_q[g];
                if (i_wr && edit_q) begin
                    if (i_addr == ch_addr(g, REG_HIGH)) high_st_d[g] = clamp(i_wdata);
                    if (i_addr == ch_addr(g, REG_LOW)) low_st_d[g] = clamp(i_wdata);
                    if (i_addr == ch_addr(g, REG_DEST)) dest_st_d[g] = i_wdata[DEST_W-1:0];
                end
                // commit on the falling edge of edit enable
                if (edit_q && !edit_d) begin
                    high_d[g] = high_st_q[g];
                    low_d[g] = low_st_q[g];
                    dest_d[g] = dest_st_q[g];
                end
            end

            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    high_st_q[g] <= HIGH_RST;
                    low_st_q[g] <= LOW_RST;
                    dest_st_q[g] <= dest_rst(g);
                    high_q[g] <= HIGH_RST;
                    low_q[g] <= LOW_RST;
                    dest_q[g] <= dest_rst(g);
                end else begin
                    high_st_q[g] <= high_st_d[g];
                    low_st_q[g] <= low_st_d[g];
                    dest_st_q[g] <= dest_st_d[g];
                    high_q[g] <= high_d[g];
                    low_q[g] <= low_d[g];
                    dest_q[g] <= dest_d[g];
                end
            end

            cdim_chan u_chan (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_term(i_term[g]),
                .i_high(high_q[g]),
                .i_low(low_q[g]),
                .o_state(state_w[g]),
                .o_value(value_w[g]),
                .o_logic(logic_w[g])
            );

            // destination stream, rewritten every cycle
            always_comb begin
                idx_d[g*DEST_W +: DEST_W] = dest_q[g];
                val_d[g*VAL_W +: VAL_W] = value_w[g];
            end
        end
    endgenerate

    // read mux: data stands one cycle after the read strobe only
    always_comb begin
        rdata_d = '0;
        if (i_rd) begin
            if (i_addr == REG_EDIT) rdata_d[0] = edit_q;
            if (i_addr == REG_STATE) begin
                rdata_d[STATE_LSB +: NUM_ALL] = state_w;
                rdata_d[CUT_BIT] = cut_q;
            end
            for (int n = 0; n < NUM_ALL; n++) begin
                if (i_addr == ch_addr(n, REG_HIGH)) rdata_d = DATA_W'(signed'(high_st_q[n]));
                if (i_addr == ch_addr(n, REG_LOW)) rdata_d = DATA_W'(signed'(low_st_q[n]));
                if (i_addr == ch_addr(n, REG_DEST)) rdata_d = DATA_W'(dest_st_q[n]);
                if (i_addr == ch_addr(n, REG_OUT)) rdata_d = DATA_W'(signed'(value_w[n]));
            end
        end
    end

    // interlock: raw terminal used, no sampling delay beyond one flop
    always_comb begin
        cut_d = i_interlock_used && !i_term[NUM_ALL-1];
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            edit_q <= 1'b0;
            rdata_q <= '0;
            idx_q <= '0;
            val_q <= '0;
            lg_q <= '0;
            wr_q <= '0;
            cut_q <= 1'b0;
        end else begin
            edit_q <= edit_d;
            rdata_q <= rdata_d;
            idx_q <= idx_d;
            val_q <= val_d;
            lg_q <= logic_w;
            wr_q <= '1;
            cut_q <= cut_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_dest_index = idx_q;
    assign o_dest_value = val_q;
    assign o_dest_logic = lg_q;
    assign o_dest_write = wr_q;
    assign o_current_off = cut_q;

    interlock_cut_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst && i_interlock_used && !i_term[NUM_ALL-1] |=> o_current_off)
        else $error("current loop not disabled");
    reset_defaults_a: assert property (@(posedge i_clk)
        $past(i_rst) && !i_rst |-> high_q[0] == HIGH_RST && low_q[0] == LOW_RST && dest_q[0] == DEST_RST_0)
        else $error("reset defaults wrong");
    edit_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        !(edit_q && !edit_d) |=> $stable(dest_q[1]) && $stable(high_q[1]))
        else $error("live map changed without commit");
    edit_commit_a: assert property (@(posedge i_clk) disable iff (i_rst)
        edit_q && !edit_d |=> dest_q[2] == $past(dest_st_q[2]))
        else $error("commit did not apply staged index");
    route_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 !$past(i_rst) |-> o_dest_index[DEST_W-1:0] == $past(dest_q[0]))
        else $error("destination index not delivered");
    stream_on_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 !$past(i_rst) |-> o_dest_write == '1)
        else $error("destination not rewritten");
    value_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
        ##2 !$past(i_rst, 2) |-> o_dest_value[VAL_W-1:0] == $past(value_w[0]))
        else $error("value not delivered unchanged");
    state_read_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_rd && i_addr == REG_STATE |=> o_rdata[STATE_LSB +: NUM_ALL] == $past(state_w))
        else $error("terminal states misread");
    cv_invert_c: cover property (@(posedge i_clk) high_q[1] == LOW_RST && low_q[1] == HIGH_RST);
    cv_commit_c: cover property (@(posedge i_clk) edit_q && !edit_d);
    cv_cut_c: cover property (@(posedge i_clk) o_current_off);
endmodule : cdim_top
